// [design/pmst_pkg.sv]
package pmst_pkg;

	// command codes
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_MAKER_STATUS = 8'h80;
	localparam logic [7:0] CMD_VIN_READING  = 8'h88;
	localparam logic [7:0] CMD_VOUT_READING = 8'h8B;

	// selector value for the whole stack
	localparam logic [7:0] PHASE_ALL = 8'hFF;

	// maker status bit positions
	localparam int unsigned ST_POR   = 7;
	localparam int unsigned ST_SELF  = 6;
	localparam int unsigned ST_RESET = 3;
	localparam int unsigned ST_CHAN  = 2;
	localparam int unsigned ST_SYNC  = 1;

	// latched, clearable bits and fixed-zero bits
	localparam logic [7:0] ST_LATCH_MASK = 8'h8E;
	localparam logic [7:0] ST_ZERO_MASK  = 8'h31;
	localparam logic [7:0] ST_RESET_VAL  = 8'h00;

	// linear11 field layout
	localparam int unsigned LIN_EXP_MSB = 15;
	localparam int unsigned LIN_EXP_LSB = 11;
	localparam int unsigned LIN_MAN_MSB = 10;
	localparam int unsigned LIN_MAN_LSB = 0;

	// reset values of link and telemetry words
	localparam logic [15:0] WORD_RESET_VAL = 16'h0000;

	// telemetry refresh timing
	localparam int unsigned CLK_SYS_MHZ  = 25;
	localparam int unsigned REFRESH_US   = 1000;
	localparam int unsigned REFRESH_CYCLES = REFRESH_US * CLK_SYS_MHZ;

	typedef struct packed {
		logic [4:0]  expo;
		logic [10:0] mant;
	} pmst_lin11_t;

	typedef struct packed {
		logic        wr;
		logic [7:0]  code;
		logic [15:0] data;
	} pmst_req_t;

	typedef enum logic [1:0] {
		SYS_IDLE   = 2'b00,
		SYS_EXEC   = 2'b01,
		SYS_ANSWER = 2'b11
	} pmst_sys_st_t;

endpackage

// [design/pmst_tgl_sync.sv]
`timescale 1ns/1ns
module pmst_tgl_sync
	import pmst_pkg::*;
(
	// destination clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// toggle from the other domain
	input  wire logic tgl_in,
	// synchronised level and change pulse
	output logic      tgl_level,
	output logic      tgl_pulse
);

	logic meta_r;
	logic sync_r;
	logic last_r;

	// meta_r feeds only sync_r
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= tgl_in;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign tgl_level = sync_r;
	assign tgl_pulse = sync_r ^ last_r;

endmodule

// [design/pmst_status_telemetry.sv]
`timescale 1ns/1ns
// Contract
// - latched status flags clear on clear-faults or by writing one there
// - bit 7 latches when trim, checksum or strap check reports invalid
// - bit 6 live: self-check running or follower silent, else zero
// - bits 5:4 and 0 read as zero always, writes ignored
// - bit 3 latches on output reset event, bit 2 on back-channel fault
// - bit 1 latches on sync fault until cleared
// - every alerting status bit has a mask bit suppressing the alert
// - input voltage word: exponent in 15:11, mantissa in 10:0
// - write to read-only telemetry pulses the invalid-command flag, raises no alert
// - selector all-phases returns loop controller input voltage
// - other selector returns input voltage of the selected phase device
// - output voltage word is 16-bit unsigned per output mode
// - loop follower reports raw sense pin voltage, ignoring loop scaling
// - latched status bits set and clear the summary bit
module pmst_status_telemetry
	import pmst_pkg::*;
#(
	parameter int unsigned REFRESH_CYC = REFRESH_CYCLES
)(
	// system clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// link side transaction port
	input  wire logic        link_clk,
	input  wire logic        link_req_valid,
	input  wire pmst_req_t   link_req,
	output logic             link_req_ready,
	output logic             link_rsp_valid,
	output logic [15:0]      link_rsp_data,
	// fault sources from the conversion core
	input  wire logic        trim_check_bad,
	input  wire logic        nvm_checksum_bad,
	input  wire logic        strap_detect_bad,
	input  wire logic        selfcheck_busy,
	input  wire logic        follower_pending,
	input  wire logic        vout_reset_evt,
	input  wire logic        back_channel_fault,
	input  wire logic        sync_fault_evt,
	// measurement path
	input  wire logic [7:0]  phase_sel,
	input  wire pmst_lin11_t power_input_supply_ctrl,
	input  wire pmst_lin11_t power_input_supply_phase,
	input  wire logic [15:0] vout_scaled,
	input  wire logic [15:0] output_sense_pin_raw,
	input  wire logic        loop_follower,
	// alert and summary
	input  wire logic [7:0]  alert_mask,
	output logic             alert_req,
	output logic             mfr_summary,
	output logic             invalid_command_flag
);

	function automatic logic is_telem(input logic [7:0] code);
		return (code == CMD_VIN_READING) || (code == CMD_VOUT_READING);
	endfunction

	function automatic logic [7:0] status_view(input logic [7:0] lat,
		input logic live);
		logic [7:0] v;
		v = lat & ST_LATCH_MASK;
		v[ST_SELF] = live;
		return v & ~ST_ZERO_MASK;
	endfunction

	// ---------------- link domain ----------------
	logic        req_tgl_r;
	pmst_req_t   req_hold_r;
	logic        ack_level;
	logic        ack_pulse;
	logic        rsp_valid_r;
	logic [15:0] rsp_link_r;
	logic        ack_tgl_r;
	logic [15:0] rsp_data_r;

	pmst_tgl_sync u_ack_sync (
		.clk       (link_clk),
		.rst_n     (rst_n),
		.tgl_in    (ack_tgl_r),
		.tgl_level (ack_level),
		.tgl_pulse (ack_pulse)
	);

	assign link_req_ready = (req_tgl_r == ack_level);

	// request held stable until the answer returns
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_tgl_r  <= 1'b0;
			req_hold_r <= '0;
		end else if (link_req_valid && link_req_ready) begin
			req_tgl_r  <= ~req_tgl_r;
			req_hold_r <= link_req;
		end
	end

	// rsp_data_r is stable while the ack toggle crosses
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid_r <= 1'b0;
			rsp_link_r  <= WORD_RESET_VAL;
		end else begin
			rsp_valid_r <= ack_pulse;
			if (ack_pulse) begin
				rsp_link_r <= rsp_data_r;
			end
		end
	end

	assign link_rsp_valid = rsp_valid_r;
	assign link_rsp_data  = rsp_link_r;

	// ---------------- system domain ----------------
	logic         req_level;
	logic         req_pulse;
	pmst_sys_st_t st_r;
	pmst_req_t    cur_r;
	logic         exec;
	logic         do_clear;
	logic         do_badcmd;
	logic [7:0]   w1c;
	logic [7:0]   set_vec;
	logic [7:0]   stat_r;
	logic [7:0]   stat_rd;
	logic         live;
	logic         summary_r;
	logic         alert_r;
	logic         badcmd_r;
	logic [31:0]  refr_cnt_r;
	logic         refr_tick;
	pmst_lin11_t  vin_ctrl_s_r;
	pmst_lin11_t  vin_phase_s_r;
	logic [15:0]  vout_s_r;

	pmst_tgl_sync u_req_sync (
		.clk       (clk_sys),
		.rst_n     (rst_n),
		.tgl_in    (req_tgl_r),
		.tgl_level (req_level),
		.tgl_pulse (req_pulse)
	);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r  <= SYS_IDLE;
			cur_r <= '0;
		end else begin
			unique case (st_r)
				SYS_IDLE: begin
					if (req_pulse) begin
						cur_r <= req_hold_r;
						st_r  <= SYS_EXEC;
					end
				end
				SYS_EXEC:   st_r <= SYS_ANSWER;
				SYS_ANSWER: st_r <= SYS_IDLE;
				default:    st_r <= SYS_IDLE;
			endcase
		end
	end

	assign exec     = (st_r == SYS_EXEC);
	assign do_clear = exec && cur_r.wr && (cur_r.code == CMD_CLEAR_FAULTS);
	assign do_badcmd = exec && cur_r.wr && is_telem(cur_r.code);
	// write-one clears only latched bits
	assign w1c = (exec && cur_r.wr && (cur_r.code == CMD_MAKER_STATUS))
		? (cur_r.data[7:0] & ST_LATCH_MASK) : 8'h00;

	always_comb begin
		set_vec = 8'h00;
		set_vec[ST_POR]   = trim_check_bad || nvm_checksum_bad
			|| strap_detect_bad;
		set_vec[ST_RESET] = vout_reset_evt;
		set_vec[ST_CHAN]  = back_channel_fault;
		set_vec[ST_SYNC]  = sync_fault_evt;
	end

	// set wins over clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= ST_RESET_VAL;
		end else begin
			stat_r <= ((stat_r & ~(do_clear ? ST_LATCH_MASK : w1c))
				| set_vec) & ST_LATCH_MASK;
		end
	end

	assign live    = selfcheck_busy || follower_pending;
	assign stat_rd = status_view(stat_r, live);

	// summary follows latched bits both ways
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			summary_r <= 1'b0;
			alert_r   <= 1'b0;
			badcmd_r  <= 1'b0;
		end else begin
			summary_r <= |(stat_r & ST_LATCH_MASK);
			alert_r   <= |(stat_r & ST_LATCH_MASK & ~alert_mask);
			badcmd_r  <= do_badcmd;
		end
	end

	assign mfr_summary          = summary_r;
	assign alert_req            = alert_r;
	assign invalid_command_flag = badcmd_r;

	assign refr_tick = (refr_cnt_r >= REFRESH_CYC - 1);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			refr_cnt_r <= 32'h00000000;
		end else if (refr_tick) begin
			refr_cnt_r <= 32'h00000000;
		end else begin
			refr_cnt_r <= refr_cnt_r + 32'h00000001;
		end
	end

	// periodic snapshot of the measurement path
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			vin_ctrl_s_r  <= '0;
			vin_phase_s_r <= '0;
			vout_s_r      <= WORD_RESET_VAL;
		end else if (refr_tick) begin
			vin_ctrl_s_r  <= power_input_supply_ctrl;
			vin_phase_s_r <= power_input_supply_phase;
			vout_s_r      <= loop_follower ? output_sense_pin_raw
				: vout_scaled;
		end
	end

	// whole word taken in one cycle, so both bytes share a sample
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rsp_data_r <= WORD_RESET_VAL;
		end else if (exec) begin
			if (cur_r.wr) begin
				rsp_data_r <= WORD_RESET_VAL;
			end else begin
				unique case (cur_r.code)
					CMD_MAKER_STATUS: rsp_data_r <= {8'h00, stat_rd};
					CMD_VIN_READING:  rsp_data_r <= (phase_sel == PHASE_ALL)
						? vin_ctrl_s_r : vin_phase_s_r;
					CMD_VOUT_READING: rsp_data_r <= vout_s_r;
					default:          rsp_data_r <= WORD_RESET_VAL;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_tgl_r <= 1'b0;
		end else if (st_r == SYS_ANSWER) begin
			ack_tgl_r <= ~ack_tgl_r;
		end
	end

	// ---------------- checks ----------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	chk_zero_bits: assert property (
		(stat_rd & ST_ZERO_MASK) == 8'h00 && (stat_r & ST_ZERO_MASK) == 8'h00)
		else $error("fixed-zero status bit set");

	chk_por_latch: assert property (
		(trim_check_bad || nvm_checksum_bad || strap_detect_bad)
		|=> stat_r[ST_POR] ##1 (stat_r[ST_POR] || $past(do_clear)
		|| $past(w1c[ST_POR])))
		else $error("power-on check flag did not latch");

	chk_self_live: assert property (
		exec && !cur_r.wr && cur_r.code == CMD_MAKER_STATUS
		|=> rsp_data_r[ST_SELF] == $past(live))
		else $error("live self-check bit wrong in answer");

	chk_event_hold: assert property (
		stat_r[ST_RESET] && !do_clear && !w1c[ST_RESET]
		|=> stat_r[ST_RESET])
		else $error("reset event flag dropped without clear");

	chk_chan_sync_set: assert property (
		(back_channel_fault |=> stat_r[ST_CHAN])
		and (sync_fault_evt |=> stat_r[ST_SYNC]))
		else $error("event flag did not latch");

	chk_clear_all: assert property (
		do_clear && set_vec == 8'h00 |=> stat_r == 8'h00)
		else $error("clear-faults left flags set");

	chk_badcmd_pulse: assert property (
		exec && cur_r.wr && is_telem(cur_r.code)
		|=> invalid_command_flag ##1 !invalid_command_flag)
		else $error("invalid-command pulse missing");

	chk_summary_follow: assert property (
		##1 mfr_summary == $past(|(stat_r & ST_LATCH_MASK)))
		else $error("summary bit out of step");

	chk_alert_mask: assert property (
		$past(stat_r & ~alert_mask) == 8'h00 |-> !alert_req)
		else $error("masked condition raised alert");

	chk_vin_phase: assert property (
		exec && !cur_r.wr && cur_r.code == CMD_VIN_READING
		|=> rsp_data_r == ($past(phase_sel) == PHASE_ALL
		? $past(vin_ctrl_s_r) : $past(vin_phase_s_r)))
		else $error("input voltage answer from wrong source");

	chk_answer_time: assert property (
		req_pulse && st_r == SYS_IDLE |-> ##3 $changed(ack_tgl_r))
		else $error("answer toggle late");

	chk_sync_hold: assert property (
		stat_r[ST_SYNC] && !do_clear && !w1c[ST_SYNC]
		|=> stat_r[ST_SYNC])
		else $error("sync fault flag dropped without clear");

	chk_bit_clear: assert property (
		w1c[ST_RESET] && !set_vec[ST_RESET] |=> !stat_r[ST_RESET])
		else $error("write-one left reset event flag set");

	chk_vout_source: assert property (
		refr_tick |=> vout_s_r == ($past(loop_follower)
		? $past(output_sense_pin_raw) : $past(vout_scaled)))
		else $error("output voltage snapshot from wrong source");

	chk_word_stable: assert property (
		!refr_tick |=> $stable(vin_ctrl_s_r) && $stable(vin_phase_s_r)
		&& $stable(vout_s_r))
		else $error("telemetry snapshot moved between refreshes");

	cov_por_set:     cover property (!stat_r[ST_POR] ##1 stat_r[ST_POR]);
	cov_clear:       cover property (do_clear && stat_r != 8'h00);
	cov_badcmd:      cover property (invalid_command_flag);
	cov_vout_raw:    cover property (refr_tick && loop_follower);
	cov_vin_follow:  cover property (exec && cur_r.code == CMD_VIN_READING
		&& phase_sel != PHASE_ALL);

endmodule

// [verif/pmst_host_model.sv]
`timescale 1ns/1ns
module pmst_host_model
	import pmst_pkg::*;
(
	// free clock in, gated link clock out
	input  wire logic        clk_free,
	output logic             link_clk,
	// transaction port
	output logic             link_req_valid,
	output pmst_req_t        link_req,
	input  wire logic        link_req_ready,
	input  wire logic        link_rsp_valid,
	input  wire logic [15:0] link_rsp_data
);
	logic run;
	initial begin
		run = 1'b0;
		link_req_valid = 1'b0;
		link_req = '0;
	end
	// clock stands still between transfers
	assign link_clk = clk_free & run;
	// one request held until taken, then wait for the answer
	task automatic xfer(input pmst_req_t rq, output logic [15:0] rd,
		output logic ok);
		int n;
		ok = 1'b0;
		rd = 16'h0000;
		@(negedge clk_free) run = 1'b1;
		repeat (3) @(posedge link_clk);
		link_req_valid <= 1'b1;
		link_req <= rq;
		for (n = 0; n < 80 && !ok; n++) begin
			@(negedge clk_free);
			ok = link_req_ready;
			@(posedge link_clk);
		end
		if (!ok)
			return;
		// released lines show the inverse, not the old value
		link_req_valid <= 1'b0;
		link_req <= ~rq;
		ok = 1'b0;
		for (n = 0; n < 80 && !ok; n++) begin
			@(negedge clk_free);
			ok = (link_rsp_valid === 1'b1);
		end
		rd = link_rsp_data;
		repeat (2) @(posedge link_clk);
		@(negedge clk_free) run = 1'b0;
	endtask
endmodule

// [verif/tb.sv]
`timescale 1ns/1ns
module tb;
	import pmst_pkg::*;
	localparam logic [7:0] EB [6] = '{8'h80, 8'h80, 8'h80, 8'h08, 8'h04,
		8'h02};
	logic        clk_sys, clk_free, rst_n, link_clk, ok;
	logic        link_req_valid, link_req_ready, link_rsp_valid;
	pmst_req_t   link_req;
	logic [15:0] link_rsp_data, rd, vout_scaled, sense_raw;
	logic [5:0]  ev;
	logic        selfcheck_busy, follower_pending, loop_follower;
	logic [7:0]  phase_sel, alert_mask;
	pmst_lin11_t vin_c, vin_p;
	logic        alert_req, mfr_summary, invalid_command_flag;
	int          miscompares = 0;
	int          comparisons = 0;
	int          icf_cnt = 0;

	pmst_status_telemetry #(.REFRESH_CYC(8)) uut (
		.clk_sys(clk_sys), .rst_n(rst_n), .link_clk(link_clk),
		.link_req_valid(link_req_valid), .link_req(link_req),
		.link_req_ready(link_req_ready), .link_rsp_valid(link_rsp_valid),
		.link_rsp_data(link_rsp_data), .trim_check_bad(ev[0]),
		.nvm_checksum_bad(ev[1]), .strap_detect_bad(ev[2]),
		.selfcheck_busy(selfcheck_busy),
		.follower_pending(follower_pending), .vout_reset_evt(ev[3]),
		.back_channel_fault(ev[4]), .sync_fault_evt(ev[5]),
		.phase_sel(phase_sel), .power_input_supply_ctrl(vin_c),
		.power_input_supply_phase(vin_p), .vout_scaled(vout_scaled),
		.output_sense_pin_raw(sense_raw), .loop_follower(loop_follower),
		.alert_mask(alert_mask), .alert_req(alert_req),
		.mfr_summary(mfr_summary),
		.invalid_command_flag(invalid_command_flag));

	pmst_host_model host (
		.clk_free(clk_free), .link_clk(link_clk),
		.link_req_valid(link_req_valid), .link_req(link_req),
		.link_req_ready(link_req_ready), .link_rsp_valid(link_rsp_valid),
		.link_rsp_data(link_rsp_data));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		clk_free = 1'b0;
		#1;
		forever #3 clk_free = ~clk_free;
	end
	always @(posedge clk_sys) begin
		if (invalid_command_flag === 1'b1)
			icf_cnt++;
	end

	task automatic close_out();
		$display("comparisons %0d miscompares %0d", comparisons,
			miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic xf(input logic w, input logic [7:0] c,
		input logic [15:0] d);
		host.xfer('{w, c, d}, rd, ok);
		if (!ok) begin
			miscompares++;
			$display("[ERR] %0t handshake got %h exp %h", $time, ok,
				1'b1);
			close_out();
		end
	endtask
	task automatic rdc(input logic [7:0] c, input logic [15:0] e);
		xf(1'b0, c, 16'h0000);
		chk(rd, e);
	endtask
	task automatic sys(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	initial begin
		rst_n = 1'b0;
		ev = '0;
		selfcheck_busy = 1'b0;
		follower_pending = 1'b0;
		loop_follower = 1'b0;
		phase_sel = PHASE_ALL;
		alert_mask = 8'h00;
		vin_c = '{5'h1A, 11'h123};
		vin_p = '{5'h03, 11'h7F5};
		vout_scaled = 16'hA55A;
		sense_raw = 16'h0C3C;
		sys(2);
		rst_n <= 1'b1;
		rdc(CMD_MAKER_STATUS, 16'h0000);
		// each source sets its bit (trim, checksum and strap share bit 7), write-one clears it
		for (int i = 0; i < 6; i++) begin
			sys(1);
			ev[i] <= 1'b1;
			sys(1);
			ev[i] <= 1'b0;
			rdc(CMD_MAKER_STATUS, {8'h00, EB[i]});
			@(negedge clk_sys);
			chk({15'h0000, mfr_summary}, 16'h0001);
			chk({15'h0000, alert_req}, 16'h0001);
			xf(1'b1, CMD_MAKER_STATUS, {8'h00, EB[i]});
			rdc(CMD_MAKER_STATUS, 16'h0000);
			@(negedge clk_sys);
			chk({15'h0000, mfr_summary}, 16'h0000);
		end
		sys(1);
		alert_mask <= ST_LATCH_MASK;
		ev <= 6'h3F;
		sys(1);
		ev <= '0;
		selfcheck_busy <= 1'b1;
		rdc(CMD_MAKER_STATUS, 16'h00CE);
		@(negedge clk_sys);
		chk({15'h0000, alert_req}, 16'h0000);
		sys(1);
		selfcheck_busy <= 1'b0;
		follower_pending <= 1'b1;
		rdc(CMD_MAKER_STATUS, 16'h00CE);
		sys(1);
		follower_pending <= 1'b0;
		xf(1'b1, CMD_MAKER_STATUS, 16'h0071);
		rdc(CMD_MAKER_STATUS, 16'h008E);
		xf(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
		rdc(CMD_MAKER_STATUS, 16'h0000);
		// telemetry after refresh
		sys(30);
		rdc(CMD_VIN_READING, vin_c);
		sys(1);
		phase_sel <= 8'h01;
		sys(30);
		rdc(CMD_VIN_READING, vin_p);
		chk({11'h000, rd[15:11]}, {11'h000, vin_p.expo});
		rdc(CMD_VOUT_READING, vout_scaled);
		sys(1);
		loop_follower <= 1'b1;
		sys(30);
		rdc(CMD_VOUT_READING, sense_raw);
		xf(1'b1, CMD_VIN_READING, 16'h1234);
		chk(rd, 16'h0000);
		xf(1'b1, CMD_VOUT_READING, 16'h1234);
		xf(1'b1, CMD_MAKER_STATUS, 16'h0000);
		sys(3);
		chk(icf_cnt[15:0], 16'h0002);
		rdc(8'h55, 16'h0000);
		close_out();
	end
endmodule
